// file: hw/cbt_top.v
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "cbt_consts.vh"
// Functional notes
// RQ1: The quantum lasts (divider+1) times 2^(1-halving select) module clocks.
// RQ2: The module clock is the system clock i_clk.
// RQ3: The sync segment is always exactly one quantum; after an early-edge resync the code keeps only the rest of the running quantum.
// RQ4: A bit is sync segment, then pre-sample, then post-sample segment.
// RQ5: The pre-sample segment lasts (field+1) quanta; software uses 2 to 15.
// RQ6: The post-sample segment lasts (field+1) quanta; software uses 1 to 7.
// RQ7: The setup register is written only while config change is allowed.
// RQ8: Recessive-to-dominant edges between sample point and next sync are used.
// RQ9: Other edges are used only while the node is not sending dominant.
// RQ10: With hard sync enabled at frame start, the bit restarts at sync.
// RQ11: A resync moves the bit by at most (jump limit+1) quanta.
// RQ12: Software keeps post >= 2 quanta and jump, pre >= 3 and jump plus delay.
// RQ13: Software programs at least 8 quanta per bit.
// RQ14: Software takes propagation time as twice the worst loop delay.
// RQ15: Clock tolerance stays within the two documented bounds.
// RQ16: A late edge lengthens pre-sample, an early edge shortens post-sample.
// RQ17: The bus is sampled once per bit at the pre/post boundary.
module cbt_top (
  input wire i_clk, // System clock, 100 MHz.
  input wire i_rst_n, // Asynchronous reset, active low.
  input wire [3:0] i_awaddr, // Write address.
  input wire i_awvalid, // Write address valid.
  output reg o_awready, // Write address ready.
  input wire [31:0] i_wdata, // Write data.
  input wire [3:0] i_wstrb, // Write strobes.
  input wire i_wvalid, // Write data valid.
  output reg o_wready, // Write data ready.
  output reg [1:0] o_bresp, // Write response.
  output reg o_bvalid, // Write response valid.
  input wire i_bready, // Write response ready.
  input wire [3:0] i_araddr, // Read address.
  input wire i_arvalid, // Read address valid.
  output reg o_arready, // Read address ready.
  output reg [31:0] o_rdata, // Read data.
  output reg [1:0] o_rresp, // Read response.
  output reg o_rvalid, // Read data valid.
  input wire i_rready, // Read data ready.
  input wire i_rx, // Bus level from transceiver, 0 is dominant.
  input wire i_tx_dominant, // Controller now sends dominant.
  input wire i_frame_idle, // Controller waits for start of frame.
  output reg o_sample_pulse, // One-cycle pulse at sample point.
  output reg o_sample_bit, // Bus level taken at sample point.
  output reg o_bit_start // One-cycle pulse at start of sync segment.
);
  // ****************************************************************
  // Registers and state.
  // ****************************************************************
  localparam SEG_SYNC = 2'h0;
  localparam SEG_PRE = 2'h1;
  localparam SEG_POST = 2'h2;
  reg [15:0] setup_ff;
  reg [2:0] ctrl_ff;
  reg aw_got_ff;
  reg w_got_ff;
  reg [3:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;
  reg [6:0] pre_cnt_ff;
  reg [1:0] seg_ff;
  reg [4:0] tq_cnt_ff;
  reg [4:0] pre_len_ff;
  reg rx_prev_ff;
  reg sync_done_ff;
  reg [3:0] resync_cnt_ff;
  reg [1:0] nxt_seg;
  reg [4:0] nxt_tq_cnt;
  reg [4:0] nxt_pre_len;
  reg nxt_sync_done;
  reg [3:0] nxt_resync_cnt;
  reg [15:0] nxt_setup;
  reg [31:0] rd_word;
  wire rx_s;
  wire [5:0] qdiv = setup_ff[`CBT_QDIV_MSB:`CBT_QDIV_LSB];
  wire [1:0] resync_jump_limit = setup_ff[`CBT_SJW_MSB:`CBT_SJW_LSB];
  wire [3:0] pre_f = setup_ff[`CBT_PRE_MSB:`CBT_PRE_LSB];
  wire [2:0] post_f = setup_ff[`CBT_POST_MSB:`CBT_POST_LSB];
  wire [2:0] jump = {1'b0, resync_jump_limit} + 3'h1;
  wire wr_fire = aw_got_ff && w_got_ff && !o_bvalid;
  wire [6:0] div_top = ctrl_ff[`CBT_CTRL_HALF] ? {1'b0, qdiv} : {qdiv, 1'b1};
  // A shortened divider must not let the counter run past its end and wrap.
  wire tq_tick = (pre_cnt_ff >= div_top);
  wire edge_any = (rx_prev_ff != rx_s);
  wire edge_fall = rx_prev_ff && !rx_s;

  // Received level synchroniser.
  cbt_sync2 u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_d(i_rx),
    .o_q(rx_s)
  );

  // ****************************************************************
  // AXI4-Lite write channel.
  // ****************************************************************
  // Setup word merge; the write is dropped unless change is allowed.
  always @* begin
    nxt_setup = setup_ff;
    if (wr_fire && (awaddr_ff == `CBT_OFS_SETUP) && ctrl_ff[`CBT_CTRL_CCE]) begin // RQ7
      if (wstrb_ff[0]) begin
        nxt_setup[7:0] = wdata_ff[7:0];
      end
      if (wstrb_ff[1]) begin
        nxt_setup[15:8] = {1'b0, wdata_ff[14:8]};
      end
    end
  end

  // Address and data are taken in either order, response after both.
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 4'h0;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= `CBT_RESP_OK;
      setup_ff <= `CBT_SETUP_RST;
      ctrl_ff <= `CBT_CTRL_RST;
    end else begin
      o_awready <= !aw_got_ff && !o_awready && !o_bvalid;
      o_wready <= !w_got_ff && !o_wready && !o_bvalid;
      if (i_awvalid && o_awready) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_got_ff <= 1'b1;
        wdata_ff <= i_wdata;
        wstrb_ff <= i_wstrb;
      end
      setup_ff <= nxt_setup;
      if (wr_fire) begin
        o_bvalid <= 1'b1;
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        o_bresp <= `CBT_RESP_OK;
        if (awaddr_ff == `CBT_OFS_CTRL) begin
          if (wstrb_ff[0]) begin
            ctrl_ff <= wdata_ff[2:0];
          end
        end else if (awaddr_ff != `CBT_OFS_SETUP && awaddr_ff != `CBT_OFS_STAT) begin
          o_bresp <= `CBT_RESP_SLVERR;
        end
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel.
  // ****************************************************************
  // Read mux; status shows segment, quantum count, sample and resyncs.
  always @* begin
    case (i_araddr)
      `CBT_OFS_SETUP: rd_word = {16'h0, setup_ff};
      `CBT_OFS_CTRL: rd_word = {29'h0, ctrl_ff};
      `CBT_OFS_STAT: rd_word = {18'h0, resync_cnt_ff, o_sample_bit, tq_cnt_ff,
                                seg_ff, sync_done_ff, rx_s};
      default: rd_word = 32'h0;
    endcase
  end

  // One-cycle-ready read with data registered on the handshake.
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0;
      o_rresp <= `CBT_RESP_OK;
    end else begin
      o_arready <= !o_arready && !o_rvalid;
      if (i_arvalid && o_arready) begin
        o_rvalid <= 1'b1;
        o_rdata <= rd_word;
        o_rresp <= (i_araddr == `CBT_OFS_SETUP || i_araddr == `CBT_OFS_CTRL ||
                    i_araddr == `CBT_OFS_STAT) ? `CBT_RESP_OK : `CBT_RESP_SLVERR;
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Quantum prescaler.
  // ****************************************************************
  // Counts system clocks; wraps after (div+1)*2^(1-half) of them.
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre_cnt_ff <= 7'h0;
    end else if (tq_tick || (edge_fall && i_frame_idle && ctrl_ff[`CBT_CTRL_HSEN])) begin // RQ1 RQ2
      pre_cnt_ff <= 7'h0;
    end else begin
      pre_cnt_ff <= pre_cnt_ff + 7'h1;
    end
  end

  // ****************************************************************
  // Bit segment sequencer.
  // ****************************************************************
  // Next segment, quantum count and resynchronisation decision.
  always @* begin
    nxt_seg = seg_ff;
    nxt_tq_cnt = tq_cnt_ff;
    nxt_pre_len = pre_len_ff;
    nxt_sync_done = sync_done_ff;
    nxt_resync_cnt = resync_cnt_ff;
    if (edge_fall && i_frame_idle && ctrl_ff[`CBT_CTRL_HSEN]) begin
      nxt_seg = SEG_SYNC; // RQ10
      nxt_tq_cnt = 5'h0;
      nxt_sync_done = 1'b1;
    end else if (edge_any && !sync_done_ff && seg_ff != SEG_SYNC &&
                 ((edge_fall && seg_ff == SEG_POST) || !i_tx_dominant)) begin // RQ8 RQ9
      nxt_sync_done = 1'b1;
      nxt_resync_cnt = resync_cnt_ff + 4'h1;
      if (seg_ff == SEG_PRE) begin
        // Late edge: stretch pre-sample by the phase error, clipped.
        if (tq_cnt_ff < {2'b0, jump}) begin
          nxt_pre_len = pre_len_ff + tq_cnt_ff; // RQ16 RQ11
        end else begin
          nxt_pre_len = pre_len_ff + {2'b0, jump}; // RQ11
        end
      end else begin
        // Early edge: cut post-sample, ending at most jump quanta early.
        if ({2'b0, post_f} - tq_cnt_ff < {2'b0, jump}) begin
          nxt_seg = SEG_SYNC; // RQ16
          nxt_tq_cnt = 5'h0;
        end else begin
          nxt_tq_cnt = tq_cnt_ff + {2'b0, jump}; // RQ11
        end
      end
    end else if (tq_tick) begin
      case (seg_ff)
        SEG_SYNC: begin
          nxt_seg = SEG_PRE; // RQ3 RQ4
          nxt_tq_cnt = 5'h0;
          nxt_pre_len = {1'b0, pre_f};
          nxt_sync_done = 1'b0;
        end
        SEG_PRE: begin
          if (tq_cnt_ff >= pre_len_ff) begin
            nxt_seg = SEG_POST; // RQ5
            nxt_tq_cnt = 5'h0;
            nxt_sync_done = 1'b0;
          end else begin
            nxt_tq_cnt = tq_cnt_ff + 5'h1;
          end
        end
        SEG_POST: begin
          if (tq_cnt_ff >= {2'b0, post_f}) begin
            nxt_seg = SEG_SYNC; // RQ6
            nxt_tq_cnt = 5'h0;
          end else begin
            nxt_tq_cnt = tq_cnt_ff + 5'h1;
          end
        end
        default: begin
          nxt_seg = SEG_SYNC;
          nxt_tq_cnt = 5'h0;
        end
      endcase
    end
  end

  // Sequencer registers and the sample and bit-start pulses.
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seg_ff <= SEG_SYNC;
      tq_cnt_ff <= 5'h0;
      pre_len_ff <= 5'h0;
      sync_done_ff <= 1'b0;
      resync_cnt_ff <= 4'h0;
      rx_prev_ff <= 1'b1;
      o_sample_pulse <= 1'b0;
      o_sample_bit <= 1'b1;
      o_bit_start <= 1'b0;
    end else begin
      seg_ff <= nxt_seg;
      tq_cnt_ff <= nxt_tq_cnt;
      pre_len_ff <= nxt_pre_len;
      sync_done_ff <= nxt_sync_done;
      resync_cnt_ff <= nxt_resync_cnt;
      rx_prev_ff <= rx_s;
      o_sample_pulse <= (seg_ff == SEG_PRE) && (nxt_seg == SEG_POST); // RQ17
      if ((seg_ff == SEG_PRE) && (nxt_seg == SEG_POST)) begin
        o_sample_bit <= rx_s; // RQ17
      end
      o_bit_start <= (nxt_seg == SEG_SYNC) && (seg_ff != SEG_SYNC || nxt_tq_cnt != tq_cnt_ff ||
                     (edge_fall && i_frame_idle && ctrl_ff[`CBT_CTRL_HSEN]));
    end
  end
endmodule

// file: common/cbt_consts.vh
`ifndef CBT_CONSTS_VH
`define CBT_CONSTS_VH
// ****************************************************************
// Register byte offsets.
// ****************************************************************
`define CBT_OFS_SETUP 4'h0
`define CBT_OFS_CTRL 4'h4
`define CBT_OFS_STAT 4'h8
// ****************************************************************
// Field positions of the bit timing setup word.
// ****************************************************************
`define CBT_QDIV_LSB 0
`define CBT_QDIV_MSB 5
`define CBT_SJW_LSB 6
`define CBT_SJW_MSB 7
`define CBT_PRE_LSB 8
`define CBT_PRE_MSB 11
`define CBT_POST_LSB 12
`define CBT_POST_MSB 14
// ****************************************************************
// Control word bits.
// ****************************************************************
`define CBT_CTRL_CCE 0
`define CBT_CTRL_HALF 1
`define CBT_CTRL_HSEN 2
// ****************************************************************
// Reset values.
// ****************************************************************
`define CBT_SETUP_RST 16'h2300
`define CBT_CTRL_RST 3'h1
// ****************************************************************
// AXI responses.
// ****************************************************************
`define CBT_RESP_OK 2'h0
`define CBT_RESP_SLVERR 2'h2
`endif

// file: hw/cbt_sync2.v
`timescale 1ns/1ps
// Two-flop synchroniser for the received bus level.
module cbt_sync2 (
  input wire i_clk, // Clock.
  input wire i_rst_n, // Asynchronous reset, active low.
  input wire i_d, // Asynchronous input.
  output reg o_q // Synchronised output.
);
  reg meta_ff;

  // Resets to recessive so no false edge appears at start.
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_ff <= 1'b1;
      o_q <= 1'b1;
    end else begin
      meta_ff <= i_d;
      o_q <= meta_ff;
    end
  end
endmodule

// file: tb/cbt_top_asserts.sv
`timescale 1ns/1ps
// ****************************************************************
// Bit timing and register bus checks.
// ****************************************************************
module cbt_top_asserts (
  input wire logic i_clk, // Clock.
  input wire logic i_rst_n, // Reset, low.
  input wire logic i_arvalid, // Read request.
  input wire logic o_arready, // Read taken.
  input wire logic o_rvalid, // Read answer.
  input wire logic i_rready, // Answer ready.
  input wire logic o_bvalid, // Write answer.
  input wire logic i_bready, // Answer ready.
  input wire logic i_rx, // Bus level.
  input wire logic o_sample_pulse, // Sample point.
  input wire logic o_sample_bit, // Sampled level.
  input wire logic o_bit_start // Sync segment.
);
  logic smp_ff;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  // Marks a bit that has already been sampled.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      smp_ff <= 1'b0;
    else if (o_bit_start)
      smp_ff <= 1'b0;
    else if (o_sample_pulse)
      smp_ff <= 1'b1;
  end
  chk_sync_one: assert property (o_bit_start |=> !o_bit_start)
    else $error("bit start pulse too long");
  chk_pre_min: assert property (o_bit_start |=> !o_sample_pulse [*3])
    else $error("sample point too early");
  chk_one_sample: assert property (o_sample_pulse |-> !smp_ff)
    else $error("second sample in one bit");
  chk_bit_hold: assert property (!$stable(o_sample_bit) |-> o_sample_pulse)
    else $error("sampled level moved off the sample point");
  chk_bit_value: assert property (o_sample_pulse |-> o_sample_bit == $past(i_rx, 3))
    else $error("sampled level wrong");
  chk_rd_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer late");
  chk_rd_done: assert property (o_rvalid && i_rready |=> !o_rvalid)
    else $error("read answer repeated");
  chk_wr_done: assert property (o_bvalid && i_bready |=> !o_bvalid)
    else $error("write answer repeated");
  cover property (o_bit_start);
  cover property (o_sample_pulse && !o_sample_bit);
  cover property (o_bvalid && i_bready);
endmodule

// file: tb/cbt_bus_model.sv
`timescale 1ns/1ps
// Far side: after an armed bit start, holds the bus dominant for LEN clocks.
module cbt_bus_model #(
  parameter int LEN = 30
) (
  input wire logic i_clk, // Clock.
  input wire logic i_arm, // Start at next bit start.
  input wire logic i_bit_start, // Bit start of block.
  input wire logic [7:0] i_at, // Delay to falling edge.
  output logic o_rx = 1'b1 // Bus, 1 is recessive.
);
  int cnt = 0;
  logic run = 1'b0;
  // Released bus returns to recessive through the termination.
  always @(posedge i_clk) begin
    if (i_arm && i_bit_start && !run) begin
      run <= 1'b1;
      cnt <= 1;
    end else if (run) begin
      cnt <= cnt + 1;
    end
    if (run && cnt == i_at)
      o_rx <= 1'b0;
    if (run && cnt == i_at + LEN) begin
      o_rx <= 1'b1;
      run <= 1'b0;
    end
  end
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ps
`include "cbt_consts.vh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin num_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [3:0] i_awaddr = 4'h0;
  logic [3:0] i_araddr = 4'h0;
  logic [3:0] i_wstrb = 4'hf;
  logic [31:0] i_wdata = 32'h0;
  logic i_awvalid = 1'b0;
  logic i_wvalid = 1'b0;
  logic i_bready = 1'b0;
  logic i_arvalid = 1'b0;
  logic i_rready = 1'b0;
  logic i_tx_dominant = 1'b0;
  logic i_frame_idle = 1'b0;
  logic arm = 1'b0;
  logic [7:0] at = 8'h0;
  logic i_rx, o_awready, o_wready, o_bvalid, o_arready, o_rvalid, sb;
  logic o_sample_pulse, o_sample_bit, o_bit_start;
  logic [1:0] o_bresp, o_rresp, resp;
  logic [31:0] o_rdata, rdv;
  int num_errors = 0;
  int compares = 0;
  int n;
  cbt_top i_cbt_top (.i_clk, .i_rst_n, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
    .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready,
    .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_rx, .i_tx_dominant, .i_frame_idle,
    .o_sample_pulse, .o_sample_bit, .o_bit_start);
  cbt_bus_model i_cbt_bus_model (.i_clk, .i_arm(arm), .i_bit_start(o_bit_start), .i_at(at),
    .o_rx(i_rx));
  // Free running 100 MHz clock.
  always #5 i_clk = ~i_clk;
  // Register write: address and data offered together, each dropped once taken.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
    end while (!o_bvalid);
    resp = o_bresp;
    i_bready <= 1'b0;
  endtask
  // Register read; data and response captured at the answering edge.
  task automatic rd(input logic [3:0] a);
    @(posedge i_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (o_arready) i_arvalid <= 1'b0;
    end while (!o_rvalid);
    rdv = o_rdata;
    resp = o_rresp;
    i_rready <= 1'b0;
  endtask
  // Measures clocks from one bit start to the next.
  task automatic per(output int c);
    do @(posedge i_clk); while (!o_bit_start);
    c = 0;
    do begin
      @(posedge i_clk);
      c++;
    end while (!o_bit_start);
  endtask
  // One dominant pulse a given delay into a bit, then four bits to settle.
  task automatic burst(input logic [7:0] a, input logic tx);
    int m;
    @(posedge i_clk);
    at <= a;
    i_tx_dominant <= tx;
    arm <= 1'b1;
    per(n);
    sb = o_sample_bit;
    arm <= 1'b0;
    per(m);
    per(m);
    i_tx_dominant <= 1'b0;
  endtask
  task automatic t_reset();
    rd(`CBT_OFS_SETUP);
    `CHK(rdv, {16'h0, `CBT_SETUP_RST});
    rd(`CBT_OFS_CTRL);
    `CHK(rdv, 32'h1);
    rd(4'hc);
    `CHK({resp, rdv}, {`CBT_RESP_SLVERR, 32'h0});
    per(n);
    `CHK(n, 16);
  endtask
  task automatic t_timing();
    wr(`CBT_OFS_SETUP, 32'h1401);
    per(n);
    per(n);
    `CHK(n, 32);
    wr(`CBT_OFS_CTRL, 32'h3);
    per(n);
    per(n);
    `CHK(n, 16);
    wr(`CBT_OFS_CTRL, 32'h1);
  endtask
  task automatic t_lock();
    wr(`CBT_OFS_CTRL, 32'h0);
    wr(`CBT_OFS_SETUP, 32'h2740);
    `CHK(resp, `CBT_RESP_OK);
    rd(`CBT_OFS_SETUP);
    `CHK(rdv, 32'h1401);
    wr(4'hc, 32'h0);
    `CHK(resp, `CBT_RESP_SLVERR);
    wr(`CBT_OFS_CTRL, 32'h1);
  endtask
  task automatic t_resync();
    wr(`CBT_OFS_SETUP, 32'h2740);
    burst(8'h5, 1'b0);
    `CHK(n, 28);
    `CHK(sb, 1'b0);
    burst(8'h5, 1'b1);
    `CHK(n, 24);
    burst(8'hf, 1'b1);
    `CHK(n, 20);
  endtask
  task automatic t_hard();
    wr(`CBT_OFS_CTRL, 32'h5);
    i_frame_idle <= 1'b1;
    burst(8'h5, 1'b0);
    `CHK(n < 16, 1'b1);
    i_frame_idle <= 1'b0;
  endtask
  task automatic results();
    $display("Errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence after reset.
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_timing();
    t_lock();
    t_resync();
    t_hard();
    results();
  end
  // Watchdog well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge i_clk);
    num_errors++;
    results();
  end
endmodule
bind cbt_top cbt_top_asserts i_cbt_top_asserts (.i_clk, .i_rst_n, .i_arvalid, .o_arready,
  .o_rvalid, .i_rready, .o_bvalid, .i_bready, .i_rx, .o_sample_pulse, .o_sample_bit,
  .o_bit_start);
